// ### bench/ep_cfg_properties.sv
// Port checker for the endpoint and pipe configuration block.
`timescale 1ns/1ps
module ep_cfg_properties #(
  parameter N_EP = 10
) (
  input wire ref_clk,
  input wire nrst,
  input wire clk_en,
  input wire [11:0] addr,
  input wire [31:0] wdata,
  input wire wr_stb,
  input wire bus_reset_rx,
  input wire bus_reset_tx,
  input wire [N_EP*2-1:0] eff_tpm,
  input wire [N_EP-1:0] ping_en,
  input wire [N_EP-1:0] token_valid,
  input wire [N_EP*2-1:0] token_type,
  input wire [N_EP*11-1:0] bank_bytes
);
  wire w = wr_stb && clk_en;
  wire rx = bus_reset_rx && clk_en;
  wire tx = bus_reset_tx && clk_en;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  AST_TOK_VALID: assert property (token_valid[0] == (token_type[1:0] != 2'h3))
    else $error("bad token valid");
  AST_BANK_POW: assert property ($onehot(bank_bytes[10:0]) && !bank_bytes[2:0])
    else $error("bad bank size");
  AST_TPM_CAP0: assert property (eff_tpm[1:0] == 2'h0)
    else $error("tpm on plain endpoint");
  AST_RX_CLR: assert property ($past(rx) |-> eff_tpm == '0)
    else $error("type kept after reset");
  AST_TX_BANK: assert property ($past(tx) |-> bank_bytes[10:0] == 11'h008)
    else $error("bank kept after reset");
  AST_TX_KEEP: assert property (tx && !wr_stb |=> $stable(token_type))
    else $error("token lost on reset");
  AST_PING_WR: assert property (w && addr == 12'h600 |=> ping_en[0] == $past(wdata[0]))
    else $error("bad ping bit");
  AST_TOK_WR: assert property (w && addr == 12'h500 |=> token_type[1:0] == $past(wdata[9:8]))
    else $error("bad token");
  cover property (tx);
  cover property (rx);
  cover property (w && addr == 12'h600);
endmodule // ep_cfg_properties
bind usb_endpoint_pipe_config ep_cfg_properties #(.N_EP(N_EP)) u_props (.*);

// ### bench/usb_endpoint_pipe_config_tb.sv
// Self-checking bench for the endpoint and pipe configuration block.
`timescale 1ns/1ps
module usb_endpoint_pipe_config_tb;
  logic ref_clk = 0;
  logic nrst = 0;
  logic [11:0] addr = 0;
  logic [31:0] wdata = 0;
  logic wr_stb = 0;
  logic rd_stb = 0;
  logic req_rx = 0;
  logic req_tx = 0;
  wire rrx, rtx;
  wire [31:0] rdata;
  wire [19:0] tpm, tok;
  wire [9:0] ping, tv;
  wire [109:0] bank;
  int failures = 0;
  int checked = 0;
  always #25 ref_clk = ~ref_clk;
  usb_far_side u_far (.ref_clk(ref_clk), .nrst(nrst), .req_rx(req_rx), .req_tx(req_tx),
    .bus_reset_rx(rrx), .bus_reset_tx(rtx));
  usb_endpoint_pipe_config dut (.ref_clk(ref_clk), .nrst(nrst), .clk_en(1'b1), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .bus_reset_rx(rrx),
    .bus_reset_tx(rtx), .eff_tpm(tpm), .ping_en(ping), .token_valid(tv),
    .token_type(tok), .bank_bytes(bank));
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1;
    @(posedge ref_clk);
    wr_stb <= 0;
    #1;
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    addr <= a;
    rd_stb <= 1;
    @(posedge ref_clk);
    rd_stb <= 0;
    #1 chk(rdata, e);
  endtask
  task usb_rst(input bit t);
    req_rx <= !t;
    req_tx <= t;
    @(posedge ref_clk);
    req_rx <= 0;
    req_tx <= 0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  task complete_run;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge ref_clk);
    nrst <= 1;
    @(posedge ref_clk);
    rd(12'h100, 32'h0);
    rd(12'h104, 32'h2000);
    for (int v = 0; v < 4; v++)
    begin
      wr(12'h104, (v << 13) | 32'h800);
      chk(tpm[3:2], v);
      rd(12'h104, (v << 13) | 32'h800);
    end
    wr(12'h100, 32'h6800);
    rd(12'h100, 32'h800);
    wr(12'h104, 32'h7000);
    chk(tpm[3:2], 32'h0);
    wr(12'h104, 32'h6808);
    usb_rst(0);
    rd(12'h104, 32'h6008);
    $display("test 1 done");
    wr(12'h500, 32'hf2670);
    rd(12'h500, 32'ha2670);
    chk(bank[10:0], 32'h400);
    usb_rst(1);
    rd(12'h500, 32'h200);
    chk(bank[10:0], 32'h8);
    $display("test 2 done");
    for (int t = 0; t < 4; t++)
    begin
      wr(12'h500, t << 8);
      chk({tok[1:0], tv[0]}, {t[1:0], t != 3});
    end
    wr(12'h600, 32'h1);
    rd(12'h600, 32'h1);
    @(posedge ref_clk);
    #1 chk(rdata, 32'h0);
    rd(12'h700, 32'h3fe);
    wr(12'h600, 32'h0);
    chk(ping[0], 32'h0);
    rd(12'h7fc, 32'h0);
    $display("test 3 done");
    complete_run;
  end
  // Generous bound: the sequence needs well under 200 cycles.
  initial
  begin
    repeat (3000) @(posedge ref_clk);
    failures++;
    complete_run;
  end
endmodule // usb_endpoint_pipe_config_tb

// ### bench/usb_far_side.sv
// Far-side model that signals bus resets to the block.
`timescale 1ns/1ps
module usb_far_side (
  input wire ref_clk,
  input wire nrst,
  input wire req_rx,
  input wire req_tx,
  output reg bus_reset_rx,
  output reg bus_reset_tx
);
  // A one-cycle pulse is the shortest reset the block must catch.
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bus_reset_rx <= 1'b0;
      bus_reset_tx <= 1'b0;
    end
    else
    begin
      bus_reset_rx <= req_rx;
      bus_reset_tx <= req_tx;
    end
  end
endmodule // usb_far_side

// ### rtl/ep_cfg_defines.vh
// Register offsets, field positions and reset values of the endpoint and pipe configuration.
`ifndef EP_CFG_DEFINES_VH
`define EP_CFG_DEFINES_VH
`define EP_CFG_BASE 12'h100
`define PIPE_CFG_BASE 12'h500
`define PIPE_PING_BASE 12'h600
`define HB_CAP_OFFSET 12'h700
`define CFG_STRIDE 12'h004
`define TPM_HI 14
`define TPM_LO 13
`define EPT_HI 12
`define EPT_LO 11
`define EP_ASW_BIT 9
`define EP_DIR_BIT 8
`define EPS_HI 6
`define EPS_LO 4
`define EPB_HI 3
`define EPB_LO 2
`define EP_ENDPOINT_MEMORY_ALLOCATE_BIT 1
`define PEP_HI 19
`define PEP_LO 16
`define PTY_HI 13
`define PTY_LO 12
`define PIPE_ASW_BIT 10
`define PTK_HI 9
`define PTK_LO 8
`define PSZ_HI 6
`define PSZ_LO 4
`define TPM_RESET 2'h1
`define PEP_MAX 4'ha
`define PTY_CONTROL 2'h0
`define PTY_BULK 2'h2
`define TOK_SETUP 2'h0
`define TOK_IN 2'h1
`define TOK_OUT 2'h2
`define TOK_RSVD 2'h3
`define EP_TYPE_ISO 2'h1
`define BANK_BYTES_MIN 11'h008
`endif

// ### rtl/ep_cfg_slot.v
// One endpoint and one pipe configuration slot.
`timescale 1ns/1ps
`include "ep_cfg_defines.vh"
module ep_cfg_slot (
  input wire ref_clk,
  input wire nrst,
  input wire clk_en,
  input wire hb_capable,
  input wire bus_reset_rx,
  input wire bus_reset_tx,
  input wire ep_wr,
  input wire pipe_wr,
  input wire ping_wr,
  input wire [31:0] wdata,
  output wire [31:0] ep_cfg,
  output wire [31:0] pipe_cfg,
  output reg ping_en_q,
  output wire [1:0] eff_tpm,
  output reg token_valid,
  output reg [1:0] token_type,
  output wire [10:0] bank_bytes
);
  reg [1:0] tpm_q;
  reg [1:0] ept_q;
  reg ep_asw_q;
  reg ep_dir_q;
  reg [2:0] eps_q;
  reg [1:0] epb_q;
  reg ep_endpoint_memory_allocate_q;
  reg [3:0] pep_q;
  reg [1:0] pty_q;
  reg pipe_asw_q;
  reg [1:0] ptk_q;
  reg [2:0] psz_q;

  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tpm_q <= `TPM_RESET;
      ept_q <= 2'h0;
      ep_asw_q <= 1'b0;
      ep_dir_q <= 1'b0;
      eps_q <= 3'h0;
      epb_q <= 2'h0;
      ep_endpoint_memory_allocate_q <= 1'b0;
      pep_q <= 4'h0;
      pty_q <= 2'h0;
      pipe_asw_q <= 1'b0;
      ptk_q <= 2'h0;
      psz_q <= 3'h0;
      ping_en_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (bus_reset_rx)
      begin
        ept_q <= 2'h0; // RULE_06
      end
      else if (ep_wr)
      begin
        if (hb_capable)
        begin
          tpm_q <= wdata[`TPM_HI:`TPM_LO]; // RULE_02
        end
        ept_q <= wdata[`EPT_HI:`EPT_LO]; // RULE_06
        ep_asw_q <= wdata[`EP_ASW_BIT];
        ep_dir_q <= wdata[`EP_DIR_BIT];
        eps_q <= wdata[`EPS_HI:`EPS_LO];
        epb_q <= wdata[`EPB_HI:`EPB_LO];
        ep_endpoint_memory_allocate_q <= wdata[`EP_ENDPOINT_MEMORY_ALLOCATE_BIT];
      end
      if (bus_reset_tx)
      begin
        pep_q <= 4'h0; // RULE_09
        pty_q <= 2'h0; // RULE_09
        pipe_asw_q <= 1'b0; // RULE_09
        psz_q <= 3'h0; // RULE_13
      end
      else if (pipe_wr)
      begin
        // Endpoint numbers above 10 are clamped to PEP_MAX, so a pipe can still target endpoint 10, which has no slot when N_EP is 10.
        pep_q <= (wdata[`PEP_HI:`PEP_LO] > `PEP_MAX) ? `PEP_MAX : wdata[`PEP_HI:`PEP_LO]; // RULE_08
        pty_q <= wdata[`PTY_HI:`PTY_LO]; // RULE_10
        pipe_asw_q <= wdata[`PIPE_ASW_BIT]; // RULE_11
        ptk_q <= wdata[`PTK_HI:`PTK_LO]; // RULE_12
        psz_q <= wdata[`PSZ_HI:`PSZ_LO]; // RULE_13
      end
      if (ping_wr)
      begin
        ping_en_q <= wdata[0]; // RULE_07
      end
    end
  end

  assign ep_cfg = {17'h0, (hb_capable ? tpm_q : 2'h0), ept_q, 1'b0, ep_asw_q, ep_dir_q, 1'b0,
                   eps_q, epb_q, ep_endpoint_memory_allocate_q, 1'b0}; // RULE_01 RULE_02
  assign pipe_cfg = {12'h0, pep_q, 2'h0, pty_q, 1'b0, pipe_asw_q, ptk_q, 1'b0, psz_q, 4'h0};
  // Only isochronous, capable endpoints see the setting.
  assign eff_tpm = (hb_capable && ept_q == `EP_TYPE_ISO) ? tpm_q : 2'h0; // RULE_05 RULE_03
  assign bank_bytes = `BANK_BYTES_MIN << psz_q; // RULE_13

  always @*
  begin
    token_type = ptk_q;
    token_valid = (ptk_q != `TOK_RSVD); // RULE_14
  end
endmodule // ep_cfg_slot

// ### rtl/usb_endpoint_pipe_config.v
// Register file holding the endpoint and pipe configurations of the USB controller.
`timescale 1ns/1ps
`include "ep_cfg_defines.vh"
// Operation
// RULE_01 - Endpoint config bits 14:13 hold transactions per microframe for high-bandwidth iso.
// RULE_02 - That field is writable only on capable endpoints, otherwise reads zero.
// RULE_03 - Encoding: 1 default one transaction, 2 two, 3 three; 0 reserved.
// RULE_04 - Software should pick double bank for two, triple bank for three.
// RULE_05 - The setting has no effect on non-isochronous endpoints.
// RULE_06 - Bits 12:11 select endpoint type, cleared on received bus reset.
// RULE_07 - Pipe ping bit: 0 disables ping, 1 applies ping flow control.
// RULE_08 - Pipe bits 19:16 hold the target endpoint number, 0 to 10.
// RULE_09 - Target endpoint, pipe type, auto switch cleared when host sends bus reset.
// RULE_10 - Pipe type bits 13:12: 0 control, 2 bulk, 1 and 3 reserved.
// RULE_11 - Pipe bit 10 enables automatic bank switching when 1.
// RULE_12 - Pipe token bits 9:8: 0 SETUP, 1 IN, 2 OUT.
// RULE_13 - Pipe bank size bits 6:4, 8 to 1024 bytes, cleared on sent reset.
// RULE_14 - Token value 3 is reserved and issues no token.
module usb_endpoint_pipe_config #(
  parameter N_EP = 10,
  parameter [9:0] HB_CAP_MASK = 10'h3fe
) (
  input wire ref_clk,
  input wire nrst,
  input wire clk_en,
  input wire [11:0] addr,
  input wire [31:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [31:0] rdata,
  input wire bus_reset_rx,
  input wire bus_reset_tx,
  output wire [N_EP*2-1:0] eff_tpm,
  output wire [N_EP-1:0] ping_en,
  output wire [N_EP-1:0] token_valid,
  output wire [N_EP*2-1:0] token_type,
  output wire [N_EP*11-1:0] bank_bytes
);
  wire [N_EP*32-1:0] ep_cfg_all;
  wire [N_EP*32-1:0] pipe_cfg_all;
  reg [31:0] rdata_d;
  integer k;

  genvar i;
  generate
    for (i = 0; i < N_EP; i = i + 1)
    begin : g_slot
      wire ep_hit = addr == (`EP_CFG_BASE + i * `CFG_STRIDE);
      wire pipe_hit = addr == (`PIPE_CFG_BASE + i * `CFG_STRIDE);
      wire ping_hit = addr == (`PIPE_PING_BASE + i * `CFG_STRIDE);
      ep_cfg_slot u_slot (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .clk_en(clk_en),
        .hb_capable(HB_CAP_MASK[i]),
        .bus_reset_rx(bus_reset_rx),
        .bus_reset_tx(bus_reset_tx),
        .ep_wr(wr_stb & ep_hit),
        .pipe_wr(wr_stb & pipe_hit),
        .ping_wr(wr_stb & ping_hit),
        .wdata(wdata),
        .ep_cfg(ep_cfg_all[i*32 +: 32]),
        .pipe_cfg(pipe_cfg_all[i*32 +: 32]),
        .ping_en_q(ping_en[i]),
        .eff_tpm(eff_tpm[i*2 +: 2]),
        .token_valid(token_valid[i]),
        .token_type(token_type[i*2 +: 2]),
        .bank_bytes(bank_bytes[i*11 +: 11])
      );
    end
  endgenerate

  // Unmapped addresses read as zero.
  always @*
  begin
    rdata_d = 32'h0;
    if (addr == `HB_CAP_OFFSET)
    begin
      rdata_d = {22'h0, HB_CAP_MASK};
    end
    for (k = 0; k < N_EP; k = k + 1)
    begin
      if (addr == `EP_CFG_BASE + k * `CFG_STRIDE)
      begin
        rdata_d = ep_cfg_all[k*32 +: 32];
      end
      if (addr == `PIPE_CFG_BASE + k * `CFG_STRIDE)
      begin
        rdata_d = pipe_cfg_all[k*32 +: 32];
      end
      if (addr == `PIPE_PING_BASE + k * `CFG_STRIDE)
      begin
        rdata_d = {31'h0, ping_en[k]};
      end
    end
  end

  // Read data stand only in the cycle after the strobe.
  always @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata <= 32'h0;
    end
    else if (clk_en)
    begin
      rdata <= rd_stb ? rdata_d : 32'h0;
    end
  end
endmodule // usb_endpoint_pipe_config
